/* File: rtl/htr_host.sv */
// Host controller for a two-wire humidity and temperature sensor.
// Assumes an external pull-up on the data wire; the clock pin is push-pull.
`timescale 1ns/1ps
`include "htr_defs.svh"

// Notes on behaviour
// - Host sets data while clock low, holds it stable while clock high.
// - Host only pulls data low or releases it, never drives it high.
// - Host waits at least 11 ms after power-up before any command.
// - Start: data falls with clock high, clock dips low once, data rises.
// - Command is three address bits 000 then five opcode bits.
// - Host waits at least 11 ms after a soft reset.
// - Host keeps clock still until it sees data-ready low.
// - Host acknowledges each received byte except the last by pulling data low.
// - Transfer ends after checksum, or after low byte with no ack.
// - Keep sensor active under 10 percent, about one measure a second.
// - Link recovery: nine clocks with data released, then back to idle; the next command sends the start.
module htr_host #(
  parameter int unsigned POWERUP_CYC     = `HTR_POWERUP_CYC,
  parameter int unsigned SRST_CYC        = `HTR_SRST_CYC,
  parameter int unsigned CONV_MAX_CYC    = `HTR_CONV_MAX_CYC,
  parameter int unsigned MEAS_PERIOD_CYC = `HTR_MEAS_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // Command request
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire htr_pkg::htr_op_type cmd_op,
  input  wire logic [7:0]        cmd_wdata,
  input  wire logic              cmd_crc,
  // Response
  output logic                   rsp_valid,
  output logic                   rsp_err,
  output logic [15:0]            rsp_data,
  output logic [7:0]             rsp_crc,
  // Sensor pins
  output logic                   sck,
  input  wire logic              data_sense,
  output logic                   data_level,
  output logic                   data_oe
);
  import htr_pkg::*;

  localparam logic [3:0] HALF_LAST = 4'(`HTR_SCK_HALF_CYC - 1);
  localparam logic [3:0] DATA_MID  = 4'(`HTR_SCK_HALF_CYC / 2);

  htr_state_type state_q;
  htr_op_type    op_q;
  logic [3:0]    half_q;
  logic [3:0]    bit_q;
  logic [2:0]    step_q;
  logic [1:0]    byte_q;
  logic [1:0]    last_idx;
  logic [7:0]    shreg_q;
  logic [7:0]    wdata_q;
  logic [23:0]   rx_q;
  logic [31:0]   wait_q;
  logic [31:0]   gap_q;
  logic [31:0]   since_rst_q;
  logic          phase_q;
  logic          second_q;
  logic          crc_en_q;
  logic          err_q;
  logic          seen_high_q;
  logic          sck_q;
  logic          oe_q;
  logic          sync1_q;
  logic          data_s_q;
  logic          tick;
  logic          mid;
  logic          is_meas;

  function automatic logic [4:0] op_code(input htr_op_type op);
    unique case (op)
      HTR_MEAS_TEMP:  op_code = `HTR_OP_MEAS_TEMP;
      HTR_MEAS_HUM:   op_code = `HTR_OP_MEAS_HUM;
      HTR_STAT_READ:  op_code = `HTR_OP_STAT_READ;
      HTR_STAT_WRITE: op_code = `HTR_OP_STAT_WRITE;
      HTR_SOFT_RESET: op_code = `HTR_OP_SOFT_RESET;
      default:        op_code = 5'h00;
    endcase
  endfunction

  function automatic logic meas_op(input htr_op_type op);
    meas_op = (op == HTR_MEAS_TEMP) || (op == HTR_MEAS_HUM);
  endfunction

  assign tick     = (half_q == 4'h0);
  assign mid      = (half_q == DATA_MID) && !phase_q;
  assign is_meas  = meas_op(op_q);
  assign last_idx = (is_meas ? 2'h1 : 2'h0) + (crc_en_q ? 2'h1 : 2'h0);
  assign sck      = sck_q;
  assign data_oe  = oe_q;
  assign data_level = 1'b0;
  assign cmd_ready = (state_q == ST_IDLE) &&
                     ((gap_q == 32'h0) || !meas_op(cmd_op));

  // Two-stage synchroniser for the data pin.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_q  <= 1'b1;
      data_s_q <= 1'b1;
    end else begin
      sync1_q  <= data_sense;
      data_s_q <= sync1_q;
    end
  end

  // Free-running half-period divider that paces the serial clock.
  always_ff @(posedge core_clk) begin
    if (srst || tick) begin
      half_q <= HALF_LAST;
    end else begin
      half_q <= half_q - 4'h1;
    end
  end

  // Long waits: power-up, conversion timeout and soft reset recovery.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wait_q <= 32'(POWERUP_CYC - 1);
    end else if (state_q == ST_TX) begin
      wait_q <= (op_q == HTR_SOFT_RESET) ? 32'(SRST_CYC - 1)
                                         : 32'(CONV_MAX_CYC - 1);
    end else if (wait_q != 32'h0) begin
      wait_q <= wait_q - 32'h1;
    end
  end

  // Spacing between measurement starts keeps self-heating low.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gap_q <= 32'h0;
    end else if (cmd_valid && cmd_ready && meas_op(cmd_op)) begin
      gap_q <= 32'(MEAS_PERIOD_CYC - 1);
    end else if (gap_q != 32'h0) begin
      gap_q <= gap_q - 32'h1;
    end
  end

  // Transfer sequencer.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q     <= ST_POWERUP;
      op_q        <= HTR_MEAS_TEMP;
      bit_q       <= 4'h0;
      step_q      <= 3'h0;
      byte_q      <= 2'h0;
      shreg_q     <= 8'h00;
      wdata_q     <= 8'h00;
      rx_q        <= 24'h00_0000;
      phase_q     <= 1'b0;
      second_q    <= 1'b0;
      crc_en_q    <= 1'b0;
      err_q       <= 1'b0;
      seen_high_q <= 1'b0;
      sck_q       <= 1'b0;
      oe_q        <= 1'b0;
    end else begin
      unique case (state_q)
        ST_POWERUP: begin
          if (wait_q == 32'h0) state_q <= ST_IDLE;
        end
        ST_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            op_q     <= cmd_op;
            crc_en_q <= cmd_crc;
            wdata_q  <= cmd_wdata;
            shreg_q  <= {`HTR_ADDR, op_code(cmd_op)};
            err_q    <= 1'b0;
            rx_q     <= 24'h00_0000;
            second_q <= 1'b0;
            byte_q   <= 2'h0;
            bit_q    <= 4'h0;
            phase_q  <= 1'b0;
            step_q   <= 3'h0;
            state_q  <= (cmd_op == HTR_LINK_RESET) ? ST_LINKRST : ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            step_q <= step_q + 3'h1;
            unique case (step_q)
              3'h0: sck_q <= 1'b1;
              3'h1: oe_q  <= 1'b1;
              3'h2: sck_q <= 1'b0;
              3'h3: sck_q <= 1'b1;
              3'h4: oe_q  <= 1'b0;
              default: begin
                sck_q   <= 1'b0;
                state_q <= ST_TX;
              end
            endcase
          end
        end
        ST_TX: begin
          if (mid) begin
            // Data moves only in the middle of the low half.
            oe_q <= (bit_q != `HTR_SLOT_ACK) && !shreg_q[7];
          end else if (tick && !phase_q) begin
            sck_q   <= 1'b1;
            phase_q <= 1'b1;
          end else if (tick) begin
            sck_q   <= 1'b0;
            phase_q <= 1'b0;
            if (bit_q != `HTR_SLOT_ACK) begin
              shreg_q <= {shreg_q[6:0], 1'b0};
              bit_q   <= bit_q + 4'h1;
            end else begin
              bit_q <= 4'h0;
              if (data_s_q) begin
                err_q   <= 1'b1;
                state_q <= ST_DONE;
              end else if (op_q == HTR_STAT_WRITE && !second_q) begin
                second_q <= 1'b1;
                shreg_q  <= wdata_q;
              end else if (is_meas) begin
                seen_high_q <= 1'b0;
                state_q     <= ST_WAIT;
              end else if (op_q == HTR_STAT_READ) begin
                state_q <= ST_RX;
              end else if (op_q == HTR_SOFT_RESET) begin
                state_q <= ST_HOLD;
              end else begin
                state_q <= ST_DONE;
              end
            end
          end
        end
        ST_WAIT: begin
          // The ack low must clear before a low can mean data-ready.
          if (wait_q == 32'h0) begin
            err_q   <= 1'b1;
            state_q <= ST_DONE;
          end else if (data_s_q) begin
            seen_high_q <= 1'b1;
          end else if (seen_high_q) begin
            state_q <= ST_RX;
          end
        end
        ST_RX: begin
          if (mid) begin
            oe_q <= (bit_q == `HTR_SLOT_ACK) && (byte_q != last_idx);
          end else if (tick && !phase_q) begin
            sck_q   <= 1'b1;
            phase_q <= 1'b1;
          end else if (tick) begin
            sck_q   <= 1'b0;
            phase_q <= 1'b0;
            if (bit_q != `HTR_SLOT_ACK) begin
              rx_q  <= {rx_q[22:0], data_s_q};
              bit_q <= bit_q + 4'h1;
            end else begin
              bit_q <= 4'h0;
              if (byte_q == last_idx) begin
                state_q <= ST_DONE;
              end else begin
                byte_q <= byte_q + 2'h1;
              end
            end
          end
        end
        ST_HOLD: begin
          if (wait_q == 32'h0) state_q <= ST_DONE;
        end
        ST_LINKRST: begin
          if (tick && !phase_q) begin
            sck_q   <= 1'b1;
            phase_q <= 1'b1;
          end else if (tick) begin
            sck_q   <= 1'b0;
            phase_q <= 1'b0;
            if (bit_q == `HTR_SLOT_ACK) begin
              bit_q   <= 4'h0;
              state_q <= ST_DONE;
            end else begin
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        ST_DONE: begin
          oe_q    <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Response capture; the result is right-justified as received.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_err   <= 1'b0;
      rsp_data  <= 16'h0000;
      rsp_crc   <= 8'h00;
    end else begin
      rsp_valid <= (state_q == ST_DONE);
      if (state_q == ST_DONE) begin
        rsp_err <= err_q;
        rsp_crc <= crc_en_q ? rx_q[7:0] : 8'h00;
        if (is_meas) begin
          rsp_data <= crc_en_q ? rx_q[23:8] : rx_q[15:0];
        end else if (op_q == HTR_STAT_READ) begin
          rsp_data <= {8'h00, crc_en_q ? rx_q[15:8] : rx_q[7:0]};
        end else begin
          rsp_data <= 16'h0000;
        end
      end
    end
  end

  // Cycles since reset, read only by the checks below.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      since_rst_q <= 32'h0;
    end else if (since_rst_q != 32'hFFFF_FFFF) begin
      since_rst_q <= since_rst_q + 32'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_data_never_high: assert property (
    data_oe |-> !data_level) else $error("data driven high");
  chk_stable_clock_high: assert property (
    (state_q == ST_TX || state_q == ST_RX) && sck_q && $past(sck_q)
    |-> $stable(oe_q)) else $error("data moved while clock high");
  chk_powerup_wait: assert property (
    (state_q == ST_START) |-> (since_rst_q >= 32'(POWERUP_CYC)))
    else $error("command before power-up wait");
  chk_start_edges: assert property (
    (state_q == ST_START) && $changed(oe_q) |-> sck_q)
    else $error("start data edge with clock low");
  chk_addr_zero: assert property (
    (state_q == ST_TX) && !second_q && (bit_q < 4'h3) && sck_q
    |-> oe_q) else $error("address bit not zero");
  chk_srst_hold: assert property (
    (state_q == ST_HOLD) && ($past(state_q) == ST_TX)
    |-> (wait_q == 32'(SRST_CYC - 1))) else $error("soft reset wait wrong");
  chk_clock_still_wait: assert property (
    (state_q == ST_WAIT) |-> !sck_q && !oe_q)
    else $error("clock toggled before data ready");
  chk_host_ack: assert property (
    (state_q == ST_RX) && (bit_q == `HTR_SLOT_ACK) && sck_q
    |-> (oe_q == (byte_q != last_idx))) else $error("host ack wrong");
  chk_meas_spacing: assert property (
    cmd_valid && cmd_ready && meas_op(cmd_op)
    |=> (gap_q == 32'(MEAS_PERIOD_CYC - 1)))
    else $error("measurement spacing not armed");
  chk_link_rst_release: assert property (
    (state_q == ST_LINKRST) |-> !oe_q) else $error("data held in recovery");

  cov_meas_done: cover property (
    (state_q == ST_DONE) && is_meas && !err_q);
  cov_nack: cover property ((state_q == ST_DONE) && err_q);
  cov_stat_write: cover property ((state_q == ST_TX) && second_q);
  cov_link_rst: cover property (
    (state_q == ST_DONE) && (op_q == HTR_LINK_RESET));

endmodule // htr_host

/* File: rtl/htr_defs.svh */
// Timing counts, command codes and link constants for the readout host.
// Assumes a 20 MHz core clock; every count is derived from that period.
`ifndef HTR_DEFS_SVH
`define HTR_DEFS_SVH

`define HTR_CLK_NS          50
`define HTR_SCK_HALF_NS     500
`define HTR_SCK_HALF_CYC \
  ((`HTR_SCK_HALF_NS + `HTR_CLK_NS - 1) / `HTR_CLK_NS)
`define HTR_POWERUP_MS      11
`define HTR_POWERUP_CYC \
  ((`HTR_POWERUP_MS * 1000000 + `HTR_CLK_NS - 1) / `HTR_CLK_NS)
`define HTR_SRST_MS         11
`define HTR_SRST_CYC \
  ((`HTR_SRST_MS * 1000000 + `HTR_CLK_NS - 1) / `HTR_CLK_NS)
`define HTR_CONV_MAX_MS     320
`define HTR_CONV_MAX_CYC \
  ((`HTR_CONV_MAX_MS * 1000000 + `HTR_CLK_NS - 1) / `HTR_CLK_NS)
`define HTR_MEAS_PERIOD_MS  1000
`define HTR_MEAS_PERIOD_CYC \
  ((`HTR_MEAS_PERIOD_MS * 1000000 + `HTR_CLK_NS - 1) / `HTR_CLK_NS)

`define HTR_ADDR            3'h0
`define HTR_OP_MEAS_TEMP    5'h03
`define HTR_OP_MEAS_HUM     5'h05
`define HTR_OP_STAT_READ    5'h07
`define HTR_OP_STAT_WRITE   5'h06
`define HTR_OP_SOFT_RESET   5'h1E
`define HTR_SLOT_ACK        4'h8

`endif

/* File: rtl/htr_pkg.sv */
// Types shared by the readout host and its users.
// Assumes htr_defs.svh carries the numeric constants.
package htr_pkg;

  typedef enum logic [2:0] {
    HTR_MEAS_TEMP  = 3'h0,
    HTR_MEAS_HUM   = 3'h1,
    HTR_STAT_READ  = 3'h2,
    HTR_STAT_WRITE = 3'h3,
    HTR_SOFT_RESET = 3'h4,
    HTR_LINK_RESET = 3'h5
  } htr_op_type;

  typedef enum logic [3:0] {
    ST_POWERUP = 4'h0,
    ST_IDLE    = 4'h1,
    ST_START   = 4'h3,
    ST_TX      = 4'h2,
    ST_WAIT    = 4'h6,
    ST_RX      = 4'h7,
    ST_HOLD    = 4'h5,
    ST_LINKRST = 4'h4,
    ST_DONE    = 4'hC
  } htr_state_type;

endpackage

/* File: sim/htr_sensor_model.sv */
// Behavioural model of the sensor at the far end of the two-wire link.
// Assumes the bench resolves the pulled-up data wire into data_w.
`timescale 1ns/1ps
module htr_sensor_model #(
  parameter logic [15:0] TEMP_VAL = 16'h1A2B,
  parameter logic [15:0] HUM_VAL  = 16'h0431,
  parameter int          CONV_NS  = 64000
) (
  // Link pins
  input  wire logic sck,
  input  wire logic data_w,
  output logic      pull_low,
  // Fault injection
  input  wire logic mute,
  input  wire logic no_ready
);
  logic [7:0]  cmd;
  logic [7:0]  wbyte;
  logic [7:0]  stat_q;
  logic [15:0] res;
  logic        acked;
  int          conv;

  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge sck) b[i] = data_w;
      @(negedge sck);
    end
  endtask

  task automatic give_ack();
    pull_low = 1'b1;
    @(negedge sck);
    #20 pull_low = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ok);
    for (int i = 7; i >= 0; i--) begin
      pull_low = ~b[i];
      @(negedge sck);
      #20;
    end
    pull_low = 1'b0;
    @(posedge sck) ok = ~data_w;
    @(negedge sck);
  endtask

  // Edge driven apart from fixed 20 ns hold delays and the conversion delay, so clock pauses are tolerated.
  initial begin
    pull_low = 1'b0;
    stat_q   = 8'h00;
    forever begin
      @(negedge data_w iff sck === 1'b1);
      @(negedge sck);
      @(negedge sck);
      get_byte(cmd);
      if (mute || cmd[7:5] != 3'h0) begin
        continue;
      end
      give_ack();
      case (cmd[4:0])
        5'h03, 5'h05: begin
          res  = (cmd[4:0] == 5'h03) ? TEMP_VAL : HUM_VAL;
          conv = (cmd[4:0] == 5'h03) ? CONV_NS : CONV_NS / 4;
          if (stat_q[0]) begin
            res  = res & ((cmd[4:0] == 5'h03) ? 16'h0FFF : 16'h00FF);
            conv = conv / 4;
          end
          if (!no_ready) begin
            #(conv);
            pull_low = 1'b1;
            put_byte(res[15:8], acked);
            put_byte(res[7:0], acked);
            if (acked) begin
              // A plain xor stands in for the checksum arithmetic.
              put_byte(cmd ^ res[15:8] ^ res[7:0], acked);
            end
          end
        end
        5'h07: begin
          put_byte(stat_q, acked);
          if (acked) begin
            put_byte(cmd ^ stat_q, acked);
          end
        end
        5'h06: begin
          get_byte(wbyte);
          stat_q = wbyte & 8'h07;
          give_ack();
        end
        5'h1E: stat_q = 8'h00;
        default: ;
      endcase
      pull_low = 1'b0;
    end
  end
endmodule // htr_sensor_model

/* File: sim/test_htr_host.sv */
// Self-checking bench for the readout host against the sensor model.
// Assumes short power-up, reset and timeout counts set on the instance.
`timescale 1ns/1ps
module test_htr_host;
  import htr_pkg::*;

  typedef struct packed {
    htr_op_type  op;
    logic [7:0]  wd;
    logic        ck;
    logic        err;
    logic [15:0] data;
    logic [7:0]  sum;
    logic [7:0]  clks;
  } htr_row_type;

  logic        core_clk  = 1'b0;
  logic        srst      = 1'b1;
  logic        cmd_valid = 1'b0;
  htr_op_type  cmd_op    = HTR_STAT_READ;
  logic [7:0]  cmd_wdata = 8'h00;
  logic        cmd_crc   = 1'b0;
  logic        mute      = 1'b0;
  logic        no_ready  = 1'b0;
  logic        cmd_ready;
  logic        rsp_valid;
  logic        rsp_err;
  logic [15:0] rsp_data;
  logic [7:0]  rsp_crc;
  logic        sck;
  logic        data_level;
  logic        data_oe;
  logic        pull_low;
  wire         data_w = (data_oe === 1'b1 || pull_low) ? 1'b0 : 1'b1;
  int          n_mismatch  = 0;
  int          comparisons = 0;
  int          n_sck = 0;
  int          n_low = 0;
  int          c0;
  int          l0;

  htr_row_type rows [10] = '{
    '{HTR_STAT_READ,  8'h00, 1'b1, 1'b0, 16'h0000, 8'h07, 8'h1D},
    '{HTR_MEAS_TEMP,  8'h00, 1'b1, 1'b0, 16'h1A2B, 8'h03 ^ 8'h1A ^ 8'h2B,
      8'h26},
    '{HTR_MEAS_HUM,   8'h00, 1'b1, 1'b0, 16'h0431, 8'h05 ^ 8'h04 ^ 8'h31,
      8'h26},
    '{HTR_STAT_WRITE, 8'h01, 1'b0, 1'b0, 16'h0000, 8'h00, 8'h14},
    '{HTR_LINK_RESET, 8'h00, 1'b0, 1'b0, 16'h0000, 8'h00, 8'h09},
    '{HTR_STAT_READ,  8'h00, 1'b1, 1'b0, 16'h0001, 8'h07 ^ 8'h01, 8'h1D},
    '{HTR_MEAS_TEMP,  8'h00, 1'b0, 1'b0, 16'h0A2B, 8'h00, 8'h1D},
    '{HTR_MEAS_HUM,   8'h00, 1'b1, 1'b0, 16'h0031, 8'h05 ^ 8'h31, 8'h26},
    '{HTR_SOFT_RESET, 8'h00, 1'b0, 1'b0, 16'h0000, 8'h00, 8'h0B},
    '{HTR_STAT_READ,  8'h00, 1'b0, 1'b0, 16'h0000, 8'h00, 8'h14}
  };

  htr_host #(
    .POWERUP_CYC     (50),
    .SRST_CYC        (50),
    .CONV_MAX_CYC    (4000),
    .MEAS_PERIOD_CYC (200)
  ) dut (
    .core_clk  (core_clk),
    .srst      (srst),
    .cmd_valid (cmd_valid),
    .cmd_ready (cmd_ready),
    .cmd_op    (cmd_op),
    .cmd_wdata (cmd_wdata),
    .cmd_crc   (cmd_crc),
    .rsp_valid (rsp_valid),
    .rsp_err   (rsp_err),
    .rsp_data  (rsp_data),
    .rsp_crc   (rsp_crc),
    .sck       (sck),
    .data_sense (data_w),
    .data_level (data_level),
    .data_oe   (data_oe)
  );

  htr_sensor_model sensor (
    .sck      (sck),
    .data_w   (data_w),
    .pull_low (pull_low),
    .mute     (mute),
    .no_ready (no_ready)
  );

  always #25 core_clk = ~core_clk;

  always @(posedge sck) begin
    n_sck++;
    if (data_w === 1'b0) begin
      n_low++;
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(posedge core_clk) begin
    if (data_oe === 1'b1) begin
      check("driven level", {15'h0, data_level}, 16'h0000);
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic reset_dut();
    srst <= 1'b1;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    check("clock at reset", {15'h0, sck}, 16'h0000);
    check("pull at reset", {15'h0, data_oe}, 16'h0000);
    repeat (40) @(posedge core_clk);
    check("early ready", {15'h0, cmd_ready}, 16'h0000);
  endtask

  task automatic run_cmd(input htr_op_type op, input logic [7:0] wd,
                         input logic ck);
    int n;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_wdata <= wd;
    cmd_crc   <= ck;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 400);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 9000);
    check("response", {15'h0, rsp_valid}, 16'h0001);
  endtask

  initial begin
    #4000000;
    n_mismatch++;
    final_report();
  end

  initial begin
    reset_dut();
    foreach (rows[i]) begin
      c0 = n_sck;
      l0 = n_low;
      run_cmd(rows[i].op, rows[i].wd, rows[i].ck);
      check("error", {15'h0, rsp_err}, {15'h0, rows[i].err});
      check("result", rsp_data, rows[i].data);
      check("checksum", {8'h00, rsp_crc}, {8'h00, rows[i].sum});
      check("clocks", 16'(n_sck - c0), {8'h00, rows[i].clks});
      if (rows[i].op == HTR_LINK_RESET) begin
        check("low in reset", 16'(n_low - l0), 16'h0000);
      end
      $display("test %0d done", i);
    end
    mute <= 1'b1;
    run_cmd(HTR_MEAS_TEMP, 8'h00, 1'b0);
    mute <= 1'b0;
    check("missing ack", {15'h0, rsp_err}, 16'h0001);
    check("clock parked", {15'h0, sck}, 16'h0000);
    $display("test nack done");
    no_ready <= 1'b1;
    run_cmd(HTR_MEAS_HUM, 8'h00, 1'b0);
    no_ready <= 1'b0;
    check("ready timeout", {15'h0, rsp_err}, 16'h0001);
    run_cmd(HTR_MEAS_HUM, 8'h00, 1'b0);
    check("recovered", rsp_data, 16'h0431);
    $display("test timeout done");
    run_cmd(HTR_STAT_WRITE, 8'h01, 1'b0);
    check("write ack", {15'h0, rsp_err}, 16'h0000);
    reset_dut();
    run_cmd(HTR_STAT_READ, 8'h00, 1'b0);
    check("status kept", rsp_data, 16'h0001);
    $display("test second reset done");
    final_report();
  end
endmodule // test_htr_host
